/* logic/rsc_pin_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_filter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic master_clear_pin_n,
  output logic filtered_low_q
);

  logic [rsc_pkg::CNT_W-1:0] low_cnt_q;
  logic [rsc_pkg::CNT_W-1:0] low_cnt_d;
  logic filtered_low_d;
  logic at_last;

  // low samples counted until the least width is reached
  assign at_last = (low_cnt_q == rsc_pkg::FILTER_LAST);
  assign filtered_low_d = !master_clear_pin_n && (at_last || filtered_low_q);
  assign low_cnt_d = master_clear_pin_n ? rsc_pkg::CNT_ZERO
                   : (at_last ? low_cnt_q : low_cnt_q + rsc_pkg::CNT_ONE);

  // counter and filtered level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_cnt_q <= rsc_pkg::CNT_ZERO;
      filtered_low_q <= 1'b0;
    end else begin
      low_cnt_q <= low_cnt_d;
      filtered_low_q <= filtered_low_d;
    end
  end

endmodule : rsc_pin_filter
`default_nettype wire

/* logic/rsc_reset_source_controller.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - low master clear pin causes reset
// - pin glitch filter, short lows ignored
// - pin reset sets external flag
// - reset instruction asserts system reset
// - instruction reset keeps clock source
// - instruction reset releases next cycle, fetch
// - instruction reset sets flag bit 6
// - watchdog time-out asserts reset asynchronously
// - watchdog reset keeps clock source
// - watchdog in sleep or idle only wakes
// - watchdog reset sets flag bit 4
// - lower hard trap during service resets
// - levels 13 to 15 are hard traps
// - address error 13, oscillator fail 14
// - trap conflict sets flag bit 15
module rsc_reset_source_controller (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic master_clear_pin_n,
  input wire logic reset_instr_exec,
  input wire logic watchdog_timeout,
  input wire logic cpu_sleep_idle,
  input wire rsc_pkg::rsc_trap_s trap_req,
  input wire logic trap_servicing,
  input wire logic [rsc_pkg::LEVEL_W-1:0] trap_service_level,
  input wire logic cause_wr_en,
  input wire logic [rsc_pkg::CAUSE_W-1:0] cause_wr_data,
  input wire logic clk_sel_wr_en,
  input wire logic [rsc_pkg::CLK_SEL_W-1:0] clk_sel_wr_data,
  output logic system_reset_signal,
  output logic reset_vector_fetch,
  output logic watchdog_wake,
  output logic [rsc_pkg::CAUSE_W-1:0] reset_cause_register,
  output rsc_pkg::rsc_cause_s last_cause,
  output logic [rsc_pkg::CLK_SEL_W-1:0] clock_source_sel
);

  // places one source flag at its bit of the cause register
  function automatic logic [rsc_pkg::CAUSE_W-1:0] flag_at(input logic set, input int unsigned pos);
    logic [rsc_pkg::CAUSE_W-1:0] one;
    one = rsc_pkg::CAUSE_ONE << pos;
    flag_at = set ? one : rsc_pkg::CAUSE_ZERO;
  endfunction : flag_at

  // implemented flag bits
  localparam logic [rsc_pkg::CAUSE_W-1:0] FLAG_MASK = flag_at(1'b1, rsc_pkg::TRAP_BIT)
                                                    | flag_at(1'b1, rsc_pkg::EXT_BIT)
                                                    | flag_at(1'b1, rsc_pkg::SW_BIT)
                                                    | flag_at(1'b1, rsc_pkg::WDT_BIT);

  rsc_pkg::rsc_state_e state_q;
  rsc_pkg::rsc_state_e state_d;
  logic [rsc_pkg::CNT_W-1:0] hold_cnt_q;
  logic [rsc_pkg::CNT_W-1:0] hold_cnt_d;
  logic rst_q;
  logic rst_d;
  logic fetch_q;
  logic fetch_d;
  logic wake_q;
  logic wake_d;
  logic [rsc_pkg::CAUSE_W-1:0] cause_q;
  logic [rsc_pkg::CAUSE_W-1:0] cause_d;
  rsc_pkg::rsc_cause_s last_q;
  rsc_pkg::rsc_cause_s last_d;
  logic [rsc_pkg::CLK_SEL_W-1:0] clk_sel_q;
  logic [rsc_pkg::CLK_SEL_W-1:0] clk_sel_d;

  logic ext_low;
  logic ext_low_q;
  logic trap_conflict;
  logic in_run;
  logic hold_done;
  logic wdt_run;
  logic wdt_sleep;
  logic wdt_async;
  logic sw_evt;
  logic trap_evt;
  logic ext_evt;
  logic [rsc_pkg::CAUSE_W-1:0] set_vec;
  logic [rsc_pkg::CAUSE_W-1:0] clr_vec;

  // master clear pin through the glitch filter
  rsc_pin_filter u_pin_filter (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .master_clear_pin_n(master_clear_pin_n),
    .filtered_low_q(ext_low)
  );

  // hard trap conflict detection
  rsc_trap_conflict u_trap_conflict (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .trap_req(trap_req),
    .trap_servicing(trap_servicing),
    .trap_service_level(trap_service_level),
    .conflict_q(trap_conflict)
  );

  // source qualification; the pin and the asynchronous watchdog path act in any state, other sources only in run
  assign in_run = (state_q == rsc_pkg::RSC_RUN);
  assign hold_done = (hold_cnt_q == rsc_pkg::CNT_ZERO);
  assign wdt_run = watchdog_timeout && !cpu_sleep_idle && in_run;
  assign wdt_sleep = watchdog_timeout && cpu_sleep_idle && in_run;
  assign wdt_async = watchdog_timeout && !cpu_sleep_idle;
  assign ext_evt = ext_low && !ext_low_q;
  assign sw_evt = reset_instr_exec && in_run && !ext_low && !wdt_run && !trap_conflict;
  assign trap_evt = trap_conflict && in_run && !ext_low && !wdt_run;

  // sequencer next state; the pin overrides every other source
  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    case (state_q)
      rsc_pkg::RSC_RUN: begin
        if (ext_low) begin
          state_d = rsc_pkg::RSC_EXT;
        end else if (wdt_run) begin
          state_d = rsc_pkg::RSC_WDT;
          hold_cnt_d = rsc_pkg::HOLD_LOAD;
        end else if (trap_conflict) begin
          state_d = rsc_pkg::RSC_TRAP;
          hold_cnt_d = rsc_pkg::HOLD_LOAD;
        end else if (reset_instr_exec) begin
          state_d = rsc_pkg::RSC_SW;
        end
      end
      rsc_pkg::RSC_EXT: begin
        if (!ext_low) begin
          state_d = rsc_pkg::RSC_RUN; // released once the pin goes high
        end
      end
      rsc_pkg::RSC_SW: begin
        if (ext_low) begin
          state_d = rsc_pkg::RSC_EXT;
        end else begin
          state_d = rsc_pkg::RSC_RUN;
        end
      end
      rsc_pkg::RSC_WDT, rsc_pkg::RSC_TRAP: begin
        if (ext_low) begin
          state_d = rsc_pkg::RSC_EXT;
        end else if (hold_done) begin
          state_d = rsc_pkg::RSC_RUN;
        end else begin
          hold_cnt_d = hold_cnt_q - rsc_pkg::CNT_ONE;
        end
      end
      default: begin
        state_d = rsc_pkg::RSC_RUN;
        hold_cnt_d = rsc_pkg::CNT_ZERO;
      end
    endcase
  end

  // reset level, vector fetch pulse and wake pulse
  assign rst_d = (state_d != rsc_pkg::RSC_RUN);
  assign fetch_d = !in_run && (state_d == rsc_pkg::RSC_RUN);
  assign wake_d = wdt_sleep;

  // flags set by the accepted events, set wins over a clearing write
  assign set_vec = flag_at(ext_evt, rsc_pkg::EXT_BIT)
                 | flag_at(sw_evt, rsc_pkg::SW_BIT)
                 | flag_at(wdt_run, rsc_pkg::WDT_BIT)
                 | flag_at(trap_evt, rsc_pkg::TRAP_BIT);
  assign clr_vec = cause_wr_en ? (~cause_wr_data & FLAG_MASK) : rsc_pkg::CAUSE_ZERO;
  assign cause_d = ((cause_q & ~clr_vec) | set_vec) & FLAG_MASK;

  // source of the most recent reset
  assign last_d.ext = ext_evt;
  assign last_d.sw = sw_evt;
  assign last_d.wdt = wdt_run;
  assign last_d.trap = trap_evt;

  // clock selection only moves on an explicit write outside reset
  assign clk_sel_d = (clk_sel_wr_en && !rst_q && !wdt_async) ? clk_sel_wr_data : clk_sel_q;

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= rsc_pkg::RSC_RUN;
      hold_cnt_q <= rsc_pkg::CNT_ZERO;
      ext_low_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      ext_low_q <= ext_low;
    end
  end

  // output pulses and reset level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_q <= 1'b0;
      fetch_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      rst_q <= rst_d;
      fetch_q <= fetch_d;
      wake_q <= wake_d;
    end
  end

  // cause flags survive every system reset, cleared only by power-on or a clearing write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cause_q <= rsc_pkg::CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  // last cause snapshot, updated only when a reset is taken
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last_q <= '0;
    end else if (last_d != '0) begin
      last_q <= last_d;
    end
  end

  // clock source held through system resets
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_sel_q <= rsc_pkg::CLK_SEL_RST;
    end else begin
      clk_sel_q <= clk_sel_d;
    end
  end

  // watchdog bypasses the flop so reset rises with the time-out itself
  assign system_reset_signal = rst_q || wdt_async;
  assign reset_vector_fetch = fetch_q;
  assign watchdog_wake = wake_q;
  assign reset_cause_register = cause_q;
  assign last_cause = last_q;
  assign clock_source_sel = clk_sel_q;

endmodule : rsc_reset_source_controller
`default_nettype wire

/* logic/rsc_trap_conflict.sv */
`timescale 1ns/1ns
`default_nettype none
module rsc_trap_conflict (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire rsc_pkg::rsc_trap_s trap_req,
  input wire logic trap_servicing,
  input wire logic [rsc_pkg::LEVEL_W-1:0] trap_service_level,
  output logic conflict_q
);

  logic req_hard;
  logic lower_prio;
  logic conflict_d;

  // a lower hard trap arriving over one already in service
  assign req_hard = trap_req.valid && rsc_pkg::rsc_is_hard_trap(trap_req.level);
  assign lower_prio = trap_req.level < trap_service_level;
  assign conflict_d = req_hard && trap_servicing && lower_prio;

  // conflict registered, high one cycle after each conflicting request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conflict_q <= 1'b0;
    end else begin
      conflict_q <= conflict_d;
    end
  end

endmodule : rsc_trap_conflict
`default_nettype wire

/* pkg/rsc_pkg.sv */
`default_nettype none
package rsc_pkg;

  // clock rate of the instruction clock
  localparam int unsigned CLK_MHZ = 25;

  // least low time on the master clear pin, in ns, and in cycles rounded up
  localparam int unsigned MASTER_CLEAR_MIN_NS = 2000;
  localparam int unsigned MASTER_CLEAR_MIN_CYC_RAW = (MASTER_CLEAR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MASTER_CLEAR_MIN_CYC = (MASTER_CLEAR_MIN_CYC_RAW < 1) ? 1 : MASTER_CLEAR_MIN_CYC_RAW;

  // hold time of a watchdog or trap reset, in ns, and in cycles rounded up
  localparam int unsigned RESET_HOLD_NS = 400;
  localparam int unsigned RESET_HOLD_CYC_RAW = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_CYC_RAW < 1) ? 1 : RESET_HOLD_CYC_RAW;

  // counter widths and load values
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] FILTER_LAST = CNT_W'(MASTER_CLEAR_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RESET_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // reset cause register layout
  localparam int unsigned CAUSE_W = 16;
  localparam int unsigned TRAP_BIT = 15;
  localparam int unsigned EXT_BIT = 7;
  localparam int unsigned SW_BIT = 6;
  localparam int unsigned WDT_BIT = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 16'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_ZERO = 16'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_ONE = 16'h0001;

  // trap priority levels
  localparam int unsigned LEVEL_W = 4;
  localparam logic [LEVEL_W-1:0] HARD_TRAP_MIN = 4'hD;
  localparam logic [LEVEL_W-1:0] HARD_TRAP_MAX = 4'hF;
  localparam logic [LEVEL_W-1:0] ADDR_ERR_LEVEL = 4'hD;
  localparam logic [LEVEL_W-1:0] OSC_FAIL_LEVEL = 4'hE;

  // clock source selection, kept across every system reset
  localparam int unsigned CLK_SEL_W = 3;
  localparam logic [CLK_SEL_W-1:0] CLK_SEL_RST = 3'h0;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    RSC_RUN  = 5'h01,
    RSC_EXT  = 5'h02,
    RSC_SW   = 5'h04,
    RSC_WDT  = 5'h08,
    RSC_TRAP = 5'h10
  } rsc_state_e;

  // one bit for each reset source
  typedef struct packed {
    logic trap;
    logic wdt;
    logic sw;
    logic ext;
  } rsc_cause_s;

  // trap request from the exception logic
  typedef struct packed {
    logic valid;
    logic [LEVEL_W-1:0] level;
  } rsc_trap_s;

  // hard traps span levels 13 to 15
  function automatic logic rsc_is_hard_trap(input logic [LEVEL_W-1:0] level);
    rsc_is_hard_trap = (level >= HARD_TRAP_MIN) && (level <= HARD_TRAP_MAX);
  endfunction : rsc_is_hard_trap

endpackage : rsc_pkg
`default_nettype wire

/* tb/rsc_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module rsc_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic master_clear_pin_n,
  input wire logic reset_instr_exec,
  input wire logic watchdog_timeout,
  input wire logic cpu_sleep_idle,
  input wire rsc_pkg::rsc_trap_s trap_req,
  input wire logic trap_servicing,
  input wire logic [rsc_pkg::LEVEL_W-1:0] trap_service_level,
  input wire logic cause_wr_en,
  input wire logic [rsc_pkg::CAUSE_W-1:0] cause_wr_data,
  input wire logic system_reset_signal,
  input wire logic reset_vector_fetch,
  input wire logic watchdog_wake,
  input wire logic [rsc_pkg::CAUSE_W-1:0] reset_cause_register,
  input wire logic [rsc_pkg::CLK_SEL_W-1:0] clock_source_sel
);
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff sys_rst;
  // consecutive low samples of the pin, saturating
  assign lo_d = master_clear_pin_n ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
  always_ff @(posedge ref_clk) begin
    lo_q <= sys_rst ? 8'h00 : lo_d;
  end
  a_instr_rst_seq: assert property (
    reset_instr_exec && !system_reset_signal && master_clear_pin_n && !watchdog_timeout
    |=> system_reset_signal && reset_cause_register[6] ##1 !system_reset_signal && reset_vector_fetch)
    else $error("instruction reset sequence wrong");
  a_wdt_async: assert property (watchdog_timeout && !cpu_sleep_idle |-> system_reset_signal)
    else $error("watchdog reset not immediate");
  a_wdt_flag_set: assert property (
    watchdog_timeout && !cpu_sleep_idle && !$past(system_reset_signal) && !$past(watchdog_timeout)
    && master_clear_pin_n |=> reset_cause_register[4])
    else $error("watchdog flag not set");
  a_sleep_wake_only: assert property (
    $rose(watchdog_timeout) && cpu_sleep_idle && !system_reset_signal |=> watchdog_wake && !system_reset_signal)
    else $error("sleep time-out handled wrongly");
  a_pin_long_reset: assert property (
    lo_q >= 8'h33 |-> system_reset_signal && reset_cause_register[7])
    else $error("long pin low without reset");
  a_pin_short_ignored: assert property (
    $rose(system_reset_signal) && !watchdog_timeout && !$past(reset_instr_exec) && !$past(trap_req.valid, 2)
    |-> lo_q >= 8'h33)
    else $error("reset from short pin low");
  a_flag_sticky: assert property (
    !cause_wr_en |=> (reset_cause_register & $past(reset_cause_register)) == $past(reset_cause_register))
    else $error("cause flag lost without write");
  a_flag_clear: assert property (
    cause_wr_en && cause_wr_data == 16'h0000 && !system_reset_signal && master_clear_pin_n && !reset_instr_exec
    && !trap_req.valid && !$past(trap_req.valid) && !watchdog_timeout |=> reset_cause_register == 16'h0000)
    else $error("cause flags not cleared");
  a_clk_sel_keep: assert property (
    system_reset_signal |=> clock_source_sel == $past(clock_source_sel))
    else $error("clock selection changed in reset");
  a_trap_conflict: assert property (
    trap_req.valid && trap_servicing && trap_req.level >= 4'hD && trap_req.level < trap_service_level
    && !system_reset_signal && master_clear_pin_n && !watchdog_timeout
    |=> ##1 reset_cause_register[15] ##1 system_reset_signal)
    else $error("trap conflict reset wrong");
  c_wake: cover property (watchdog_wake);
  c_trap_fetch: cover property (reset_vector_fetch && reset_cause_register[15]);
  c_pin_long: cover property (lo_q == 8'h33);
endmodule : rsc_props
bind rsc_reset_source_controller rsc_props u_props (.*);
`default_nettype wire

/* tb/rsc_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
// external supervisor driving the master clear pin
module rsc_supervisor (
  input wire logic ref_clk,
  output var logic master_clear_pin_n
);
  initial master_clear_pin_n = 1'b1;
  // pin held low for n rising edges, changed at falling edges
  task automatic pulse(input int n);
    @(negedge ref_clk);
    master_clear_pin_n = 1'b0;
    repeat (n) @(negedge ref_clk);
    master_clear_pin_n = 1'b1;
  endtask : pulse
endmodule : rsc_supervisor
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic master_clear_pin_n;
  logic reset_instr_exec = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic cpu_sleep_idle = 1'b0;
  rsc_pkg::rsc_trap_s trap_req = '0;
  logic trap_servicing = 1'b0;
  logic [3:0] trap_service_level = 4'h0;
  logic cause_wr_en = 1'b0;
  logic [15:0] cause_wr_data = 16'h0000;
  logic clk_sel_wr_en = 1'b0;
  logic [2:0] clk_sel_wr_data = 3'h0;
  logic system_reset_signal;
  logic reset_vector_fetch;
  logic watchdog_wake;
  logic [15:0] reset_cause_register;
  rsc_pkg::rsc_cause_s last_cause;
  logic [2:0] clock_source_sel;
  logic [15:0] exp_q[$];
  logic [2:0] sel = 3'h0;
  logic [3:0] lv;
  logic [3:0] last_exp = 4'h0;
  logic [15:0] exp_trap;
  logic [31:0] seed = 32'h00012299;
  int fail_count = 0;
  int n_compared = 0;
  always #20 ref_clk = ~ref_clk;
  rsc_supervisor sup (.ref_clk(ref_clk), .master_clear_pin_n(master_clear_pin_n));
  rsc_reset_source_controller uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .master_clear_pin_n(master_clear_pin_n),
    .reset_instr_exec(reset_instr_exec), .watchdog_timeout(watchdog_timeout), .cpu_sleep_idle(cpu_sleep_idle),
    .trap_req(trap_req), .trap_servicing(trap_servicing), .trap_service_level(trap_service_level),
    .cause_wr_en(cause_wr_en), .cause_wr_data(cause_wr_data), .clk_sel_wr_en(clk_sel_wr_en),
    .clk_sel_wr_data(clk_sel_wr_data), .system_reset_signal(system_reset_signal),
    .reset_vector_fetch(reset_vector_fetch), .watchdog_wake(watchdog_wake),
    .reset_cause_register(reset_cause_register), .last_cause(last_cause), .clock_source_sel(clock_source_sel));
  // compare seen against expected and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic write(input logic [15:0] d);
    cause_wr_en = 1'b1;
    cause_wr_data = d;
    cyc(1);
    cause_wr_en = 1'b0;
  endtask : write
  // random clock selection written before the software and watchdog resets
  task automatic set_sel();
    logic [31:0] r;
    r = xs();
    sel = r[2:0];
    clk_sel_wr_en = 1'b1;
    clk_sel_wr_data = sel;
    cyc(1);
    clk_sel_wr_en = 1'b0;
  endtask : set_sel
  // note the expected cause, wait for release, then probe the flags
  task automatic settle(input string name, input logic [15:0] expv);
    int i;
    if (expv != 16'h0000) begin
      exp_q.push_back(expv);
      for (i = 0; i < 300 && reset_vector_fetch !== 1'b1; i++) cyc(1);
      if (i == 300) begin
        fail_count++;
        finish_test();
      end
      last_exp = {expv[rsc_pkg::TRAP_BIT], expv[rsc_pkg::WDT_BIT], expv[rsc_pkg::SW_BIT], expv[rsc_pkg::EXT_BIT]};
    end else cyc(20);
    check("system_reset_signal", system_reset_signal, 16'h0000);
    check("clksel", clock_source_sel, {13'h0000, sel});
    check("last", {12'h000, last_cause}, {12'h000, last_exp});
    write(16'hFFFF);
    check("sticky", reset_cause_register, expv);
    cyc(1);
    write(16'h0000);
    check("cleared", reset_cause_register, 16'h0000);
    $display("done %s", name);
  endtask : settle
  // oldest note against the cause register at each fetch pulse, off the launching edge
  always @(negedge ref_clk) begin
    if (reset_vector_fetch === 1'b1) begin
      if (exp_q.size() == 0) check("fetch", 16'h0001, 16'h0000);
      else check("cause", reset_cause_register, exp_q.pop_front());
    end
  end
  initial begin
    cyc(8);
    sys_rst = 1'b0;
    check("rst cause", reset_cause_register, 16'h0000);
    check("rst sel", clock_source_sel, 16'h0000);
    set_sel();
    reset_instr_exec = 1'b1;
    cyc(1);
    reset_instr_exec = 1'b0;
    check("sw rst", system_reset_signal, 16'h0001);
    check("sw last", last_cause.sw, 16'h0001);
    settle("software", 16'h0040);
    set_sel();
    cyc(1);
    // clock selection write racing the time-out must be ignored
    watchdog_timeout = 1'b1;
    clk_sel_wr_en = 1'b1;
    clk_sel_wr_data = ~sel;
    #1 check("wdt rst", system_reset_signal, 16'h0001);
    cyc(1);
    watchdog_timeout = 1'b0;
    clk_sel_wr_en = 1'b0;
    settle("watchdog", 16'h0010);
    cpu_sleep_idle = 1'b1;
    watchdog_timeout = 1'b1;
    #1 check("sleep rst", system_reset_signal, 16'h0000);
    cyc(1);
    watchdog_timeout = 1'b0;
    check("wake", watchdog_wake, 16'h0001);
    cpu_sleep_idle = 1'b0;
    settle("sleep", 16'h0000);
    trap_servicing = 1'b1;
    trap_service_level = 4'hF;
    for (int l = 0; l < 4; l++) begin
      lv = 4'hC + 4'(l);
      exp_trap = (lv == rsc_pkg::ADDR_ERR_LEVEL || lv == rsc_pkg::OSC_FAIL_LEVEL) ? 16'h8000 : 16'h0000;
      trap_req.valid = 1'b1;
      trap_req.level = lv;
      cyc(1);
      trap_req.valid = 1'b0;
      settle("trap", exp_trap);
    end
    trap_servicing = 1'b0;
    sup.pulse(49);
    settle("short pin", 16'h0000);
    sup.pulse(60);
    settle("pin", 16'h0080);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
